//--- logic/high_port_bank_io.sv
// Output latches, nibble output modes, pull-up control and memory-interface
// override for ports 4 to 7.
// Assumes register requests and memory-interface signals share core_clk; pins are async.

// How it works
// - Pull-ups are on after reset and a high pullup_global_disable turns all of them off.
// - A pin driven low always has its own pull-up switched off.
// - During an off-chip move the memory interface sets the affected pins, not the latches.
// - Moves leave output modes alone, except that data pins float during an off-chip read.
// - Each mode bit sets one nibble open-drain (0) or push-pull (1), bit 0 for port 4 low.
// - A latch 0 drives low; a 1 drives high in push-pull or floats in open-drain.
// - Reading a port data register returns the synchronised pin levels.
// - Port 4 pins 7, 6, 5 carry write strobe, read strobe and address latch enable.
// - Port 5 carries address 15:8 in non-multiplexed mode.
// - Port 6 carries address 15:8 multiplexed and address 7:0 non-multiplexed.
// - Port 7 carries address/data multiplexed and data alone non-multiplexed.
// - The read phase of a read-modify-write returns the latch contents.
module high_port_bank_io
   import high_port_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic pullup_global_disable,
   input wire logic memif_low_port_select,
   input wire memif_type memif,
   input wire port_bank_type pin_in,
   output port_bank_type pin_out,
   output port_bank_type pin_oe,
   output port_bank_type pullup_en
);

   // ==========================================================
   // Local constants
   localparam int NIBBLES_PER_PORT = PORT_W / NIBBLE_W;
   // Port 4 low bits are never taken over by the memory interface
   localparam int LATCH_ONLY_MSB = ALE_BIT - 1;
   localparam int LATCH_ONLY_LSB = 0;
   // Probe pin for the bit-level checks: port 4 bit 0, governed by mode bit 0
   localparam int CHK_PIN = 0;
   localparam int CHK_MODE_BIT = P4_IDX * NIBBLES_PER_PORT + CHK_PIN / NIBBLE_W;

   // ==========================================================
   // Registers and combinational signals
   port_bank_type latch_r;
   logic [7:0] nibble_mode_r;
   port_bank_type sync1_r;
   port_bank_type sync2_r;
   port_bank_type pin_out_r;
   port_bank_type pin_oe_r;
   port_bank_type pullup_en_r;
   logic [7:0] rdata_r;
   logic hit_r;
   logic [NUM_PORTS-1:0] latch_sel;
   logic mode_sel;
   logic any_hit;
   port_bank_type out_nxt;
   port_bank_type oe_nxt;
   port_bank_type pullup_nxt;
   logic [7:0] rdata_nxt;

   assign latch_sel[P4_IDX] = (sfr_req.addr == OFS_PORT4_LATCH);
   assign latch_sel[P5_IDX] = (sfr_req.addr == OFS_PORT5_LATCH);
   assign latch_sel[P6_IDX] = (sfr_req.addr == OFS_PORT6_LATCH);
   assign latch_sel[P7_IDX] = (sfr_req.addr == OFS_PORT7_LATCH);
   assign mode_sel = (sfr_req.addr == OFS_NIBBLE_MODE);
   assign any_hit = mode_sel | (|latch_sel);

   // ==========================================================
   // Port latches and nibble modes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         latch_r <= {NUM_PORTS{RST_LATCH}};
      end else if (sfr_req.wr) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (latch_sel[p]) begin
               latch_r[p] <= sfr_req.wdata;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         nibble_mode_r <= RST_NIBBLE_MODE;
      end else if (sfr_req.wr && mode_sel) begin
         nibble_mode_r <= sfr_req.wdata;
      end
   end

   // ==========================================================
   // Pin input synchroniser
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end

   // ==========================================================
   // Register read: pins normally, latches in the read phase of read-modify-write
   always_comb begin
      rdata_nxt = READ_ZERO;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (latch_sel[p]) begin
            rdata_nxt = sfr_req.rmw ? latch_r[p] : sync2_r[p];
         end
      end
      if (mode_sel) begin
         rdata_nxt = nibble_mode_r;
      end
   end

   // Unmapped addresses answer zero with sfr_hit low
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_r <= READ_ZERO;
         hit_r <= 1'b0;
      end else if (sfr_req.rd) begin
         rdata_r <= rdata_nxt;
         hit_r <= any_hit;
      end else begin
         hit_r <= 1'b0;
      end
   end

   // ==========================================================
   // Pin drive
   always_comb begin
      out_nxt = latch_r;
      oe_nxt = '0;
      pullup_nxt = '0;
      if (memif.active) begin
         out_nxt[P4_IDX][WR_STROBE_BIT] = memif.wr_n;
         out_nxt[P4_IDX][RD_STROBE_BIT] = memif.rd_n;
         out_nxt[P4_IDX][ALE_BIT] = memif.ale;
         if (!memif.multiplexed) begin
            out_nxt[P5_IDX] = memif.addr[ADDR_HI_MSB:ADDR_HI_LSB];
            out_nxt[P6_IDX] = memif.addr[ADDR_LO_MSB:ADDR_LO_LSB];
         end else begin
            out_nxt[P6_IDX] = memif.addr[ADDR_HI_MSB:ADDR_HI_LSB];
         end
         out_nxt[P7_IDX] = memif.bus_out;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            // Open-drain drives only a low; push-pull drives both levels
            oe_nxt[p][b] = nibble_mode_r[p*NIBBLES_PER_PORT + b/NIBBLE_W]
               | ~out_nxt[p][b];
         end
      end
      if (memif.active && memif.read) begin
         oe_nxt[P7_IDX] = '0;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            // Never fight our own low drive
            pullup_nxt[p][b] = ~pullup_global_disable
               & ~(oe_nxt[p][b] & ~out_nxt[p][b]);
         end
      end
   end

   // Registered so pins never glitch on decode paths; one cycle of latency
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_out_r <= {NUM_PORTS{RST_LATCH}};
         pin_oe_r <= '0;
         pullup_en_r <= {NUM_PORTS{RST_LATCH}};
      end else begin
         pin_out_r <= out_nxt;
         pin_oe_r <= oe_nxt;
         pullup_en_r <= pullup_nxt;
      end
   end

   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign pullup_en = pullup_en_r;
   assign sfr_rdata = rdata_r;
   assign sfr_hit = hit_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_memif_read;
      memif.active && memif.read;
   endsequence

   sequence s_data_floating;
      pin_oe_r[P7_IDX] == '0;
   endsequence

   sequence s_p4_write;
      sfr_req.wr && sfr_req.addr == OFS_PORT4_LATCH;
   endsequence

   a_reset_pullups: assert property (
      $fell(sys_rst) |-> pullup_en_r == {NUM_PORTS{RST_LATCH}}
         && latch_r == {NUM_PORTS{RST_LATCH}})
      else $error("pull-ups or latches not at reset value");
   a_global_disable: assert property (
      pullup_global_disable |=> pullup_en_r == '0)
      else $error("pull-up still on while globally disabled");
   a_low_no_pullup: assert property (
      (pin_oe_r & ~pin_out_r & pullup_en_r) == '0)
      else $error("pull-up on a pin driven low");
   a_read_float: assert property (
      s_memif_read |=> s_data_floating)
      else $error("data pins driven during off-chip read");
   a_bus_override: assert property (
      memif.active && !memif.read |=> pin_out_r[P7_IDX] == $past(memif.bus_out))
      else $error("port 7 not carrying memory interface byte");
   a_strobe_map: assert property (
      memif.active |=> pin_out_r[P4_IDX][WR_STROBE_BIT] == $past(memif.wr_n)
         && pin_out_r[P4_IDX][ALE_BIT] == $past(memif.ale))
      else $error("strobe pins not following memory interface");
   a_addr_split: assert property (
      memif.active && !memif.multiplexed |=>
         pin_out_r[P6_IDX] == $past(memif.addr[ADDR_LO_MSB:ADDR_LO_LSB])
         && pin_out_r[P5_IDX] == $past(memif.addr[ADDR_HI_MSB:ADDR_HI_LSB]))
      else $error("address bytes misplaced in non-multiplexed mode");
   a_open_drain: assert property (
      !memif.active && !nibble_mode_r[CHK_MODE_BIT] && latch_r[P4_IDX][CHK_PIN]
         |=> !pin_oe_r[P4_IDX][CHK_PIN])
      else $error("open-drain pin driving high");
   a_latch_write: assert property (
      s_p4_write ##1 (!sfr_req.wr)[*2] ##0 (!memif.active && nibble_mode_r[CHK_MODE_BIT])
         |=> pin_out_r[P4_IDX][CHK_PIN] == $past(sfr_req.wdata[CHK_PIN], 3)
         && pin_oe_r[P4_IDX][CHK_PIN])
      else $error("latch write not reaching push-pull pin");
   a_pin_readback: assert property (
      sfr_req.rd && !sfr_req.rmw && sfr_req.addr == OFS_PORT5_LATCH
         |=> sfr_rdata == $past(sync2_r[P5_IDX]) && sfr_hit)
      else $error("port read not returning pin levels");
   a_rmw_latch: assert property (
      sfr_req.rd && sfr_req.rmw && sfr_req.addr == OFS_PORT7_LATCH
         |=> sfr_rdata == $past(latch_r[P7_IDX]))
      else $error("read-modify-write not returning latch");

   // ==========================================================
   // Further pin and register checks
   sequence s_memif_mux;
      memif.active && memif.multiplexed;
   endsequence

   sequence s_latch_drive;
      !memif.active;
   endsequence

   // Memory interface takeover
   a_rd_strobe: assert property (
      memif.active |=> pin_out_r[P4_IDX][RD_STROBE_BIT] == $past(memif.rd_n))
      else $error("read strobe pin not following memory interface");
   a_mux_addr_hi: assert property (
      s_memif_mux |=> pin_out_r[P6_IDX] == $past(memif.addr[ADDR_HI_MSB:ADDR_HI_LSB]))
      else $error("port 6 not carrying high address in multiplexed mode");
   a_mux_p5_latch: assert property (
      s_memif_mux |=> pin_out_r[P5_IDX] == $past(latch_r[P5_IDX]))
      else $error("port 5 taken over in multiplexed mode");
   a_p4_low_pins: assert property (
      memif.active |=> pin_out_r[P4_IDX][LATCH_ONLY_MSB:LATCH_ONLY_LSB]
         == $past(latch_r[P4_IDX][LATCH_ONLY_MSB:LATCH_ONLY_LSB]))
      else $error("port 4 low pins left latch drive during a move");
   a_read_pullup: assert property (
      s_memif_read ##0 !pullup_global_disable |=> pullup_en_r[P7_IDX] == {PORT_W{1'b1}})
      else $error("data pin pull-ups off during off-chip read");

   // Latch drive and pull-ups; the bench randomises latch and mode, so every case occurs
   a_release_latch: assert property (
      s_latch_drive |=> pin_out_r == $past(latch_r))
      else $error("pins not on latch drive outside a move");
   a_push_pull: assert property (
      !memif.active && nibble_mode_r[CHK_MODE_BIT] |=> pin_oe_r[P4_IDX][CHK_PIN])
      else $error("push-pull pin not driving");
   a_low_drive: assert property (
      !memif.active && !latch_r[P4_IDX][CHK_PIN]
         |=> pin_oe_r[P4_IDX][CHK_PIN] && !pin_out_r[P4_IDX][CHK_PIN])
      else $error("latch zero not driving pin low");
   a_pullup_high: assert property (
      !pullup_global_disable && !memif.active && latch_r[P4_IDX][CHK_PIN]
         |=> pullup_en_r[P4_IDX][CHK_PIN])
      else $error("pull-up off on a pin not driven low");
   a_reset_drive: assert property (
      $fell(sys_rst) |-> pin_oe_r == '0 && nibble_mode_r == RST_NIBBLE_MODE)
      else $error("pins driving or modes set straight after reset");

   // Register side
   a_mode_write: assert property (
      sfr_req.wr && mode_sel |=> nibble_mode_r == $past(sfr_req.wdata))
      else $error("nibble mode register not taking written byte");
   a_mode_readback: assert property (
      sfr_req.rd && mode_sel |=> sfr_rdata == $past(nibble_mode_r) && sfr_hit)
      else $error("nibble mode register not reading back");
   a_p7_write: assert property (
      sfr_req.wr && sfr_req.addr == OFS_PORT7_LATCH |=> latch_r[P7_IDX] == $past(sfr_req.wdata))
      else $error("port 7 latch not taking written byte");
   // Skips the two edges after reset, while the stages still hold their reset value
   a_pin_sync: assert property (
      !$past(sys_rst) && !$past(sys_rst, 2) |-> sync2_r == $past(pin_in, 2))
      else $error("pin synchroniser not two stages deep");

endmodule

//--- pkg/high_port_pkg.sv
// Constants and carriers for the high-port bank I/O block.
// Assumes an SFR-style register port and a memory interface on the same clock.
package high_port_pkg;

   // ==========================================================
   // Register offsets in SFR space
   localparam logic [7:0] OFS_PORT4_LATCH = 8'h84;
   localparam logic [7:0] OFS_PORT5_LATCH = 8'h85;
   localparam logic [7:0] OFS_PORT6_LATCH = 8'h86;
   localparam logic [7:0] OFS_PORT7_LATCH = 8'h96;
   localparam logic [7:0] OFS_NIBBLE_MODE = 8'hb5;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_LATCH = 8'hff;
   localparam logic [7:0] RST_NIBBLE_MODE = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ==========================================================
   // Port and pin positions
   localparam int NUM_PORTS = 4;
   localparam int PORT_W = 8;
   localparam int NIBBLE_W = 4;
   localparam int P4_IDX = 0;
   localparam int P5_IDX = 1;
   localparam int P6_IDX = 2;
   localparam int P7_IDX = 3;
   localparam int WR_STROBE_BIT = 7;
   localparam int RD_STROBE_BIT = 6;
   localparam int ALE_BIT = 5;
   localparam int ADDR_HI_MSB = 15;
   localparam int ADDR_HI_LSB = 8;
   localparam int ADDR_LO_MSB = 7;
   localparam int ADDR_LO_LSB = 0;

   typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_bank_type;

   // Register access request from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic rmw;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

   // Memory interface drive, valid during the execution phase of an off-chip move
   typedef struct packed {
      logic active;
      logic read;
      logic multiplexed;
      logic wr_n;
      logic rd_n;
      logic ale;
      logic [15:0] addr;
      logic [7:0] bus_out;
   } memif_type;

endpackage

//--- sim/pin_partner.sv
// Wire model of the high-port pins: device drivers, pull-ups, open-drain neighbour.
// Assumes pin vectors indexed port4 = [0] as the design package lays out.
module pin_partner
   import high_port_pkg::*;
(
   input wire logic core_clk,
   input wire port_bank_type pin_out,
   input wire port_bank_type pin_oe,
   input wire port_bank_type pullup_en,
   input wire port_bank_type ext_low,
   output port_bank_type pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic flip_r = 1'b0;
   // Undriven pins with no pull-up wander every cycle, so no check may lean on them
   always @(posedge core_clk) flip_r <= ~flip_r;
   // A low from anyone wins; the bench pulls ext_low against high drive and expects the low
   assign pin_in = ~((pin_oe & ~pin_out) | ext_low)
                 & ((pin_oe & pin_out) | pullup_en | {(NUM_PORTS*PORT_W){flip_r}});
endmodule

//--- sim/tb_top.sv
// Self-checking bench for high_port_bank_io against a bit-level reference model.
// Assumes pin_partner for the pin wires and a 10 MHz core clock.
module tb_top
   import high_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pu_off = 1'b0;
   sfr_req_type sfr_req = '0;
   memif_type memif = '0;
   logic [7:0] sfr_rdata;
   logic sfr_hit;
   port_bank_type pin_in, pin_out, pin_oe, pullup_en;
   port_bank_type ext_low = '0;
   logic [31:0] lat = 32'hffff_ffff;
   logic [31:0] eo, xoe, xpu, pinx;
   logic [7:0] mode = 8'h00;
   logic [7:0] ofs [4] = '{OFS_PORT4_LATCH, OFS_PORT5_LATCH, OFS_PORT6_LATCH, OFS_PORT7_LATCH};
   int error_cnt = 0;
   int compares = 0;
   localparam int MEMIF_W = $bits(memif_type);
   memif_type mv;

   always #50 core_clk = ~core_clk;

   high_port_bank_io i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .pullup_global_disable(pu_off),
      .memif_low_port_select(1'b0), .memif(memif), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en));
   pin_partner i_wire (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pullup_en), .ext_low(ext_low), .pin_in(pin_in));

   // ==========================================================
   // Reference model and checks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic settle();
      logic [31:0] ovm, ovv, md;
      ovm = '0;
      ovv = '0;
      repeat (2) @(negedge core_clk);
      if (memif.active) begin
         ovm[7:5] = 3'b111;
         ovv[7:5] = {memif.wr_n, memif.rd_n, memif.ale};
         ovm[15:8] = {8{~memif.multiplexed}};
         ovv[15:8] = memif.addr[15:8];
         ovm[23:16] = 8'hff;
         ovv[23:16] = memif.multiplexed ? memif.addr[15:8] : memif.addr[7:0];
         ovm[31:24] = 8'hff;
         ovv[31:24] = memif.bus_out;
      end
      for (int n = 0; n < 8; n++)
         md[n*4 +: 4] = {4{mode[n]}};
      eo = (ovm & ovv) | (~ovm & lat);
      // Open-drain nibbles drive only their zeros
      xoe = md | ~eo;
      if (memif.active && memif.read)
         xoe[31:24] = 8'h00;
      xpu = pu_off ? 32'h0000_0000 : ~(xoe & ~eo);
      chk(pin_out & pin_oe, eo & xoe);
      chk(pin_oe, xoe);
      chk(pullup_en, xpu);
   endtask

   // ==========================================================
   // Register port drivers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_req.wr = 1'b1;
      sfr_req.addr = a;
      sfr_req.wdata = d;
      @(negedge core_clk);
      sfr_req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input logic h);
      @(negedge core_clk);
      sfr_req.rd = 1'b1;
      sfr_req.rmw = m;
      sfr_req.addr = a;
      @(negedge core_clk);
      sfr_req.rd = 1'b0;
      chk(32'(sfr_rdata), 32'(e));
      chk(32'(sfr_hit), 32'(h));
   endtask

   task automatic stop_test();
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(54920));
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      settle();
      for (int p = 0; p < 4; p++)
         rd(ofs[p], 1'b1, 8'hff, 1'b1);
      rd(OFS_NIBBLE_MODE, 1'b0, RST_NIBBLE_MODE, 1'b1);
      rd(8'h90, 1'b0, 8'h00, 1'b0);
      repeat (30) begin
         mode = 8'($urandom);
         wr(OFS_NIBBLE_MODE, mode);
         // Port 4 goes last so its pin settles with no write behind it
         for (int p = 3; p >= 0; p--) begin
            lat[p*8 +: 8] = 8'($urandom);
            wr(ofs[p], lat[p*8 +: 8]);
         end
         pu_off = 1'($urandom);
         ext_low = $urandom & $urandom;
         settle();
         // Pins need two more edges through the input synchroniser
         repeat (2) @(negedge core_clk);
         pinx = ~((xoe & ~eo) | ext_low);
         for (int p = 0; p < 4; p++) begin
            if (!pu_off)
               rd(ofs[p], 1'b0, pinx[p*8 +: 8], 1'b1);
            rd(ofs[p], 1'b1, lat[p*8 +: 8], 1'b1);
         end
         rd(OFS_NIBBLE_MODE, 1'b0, mode, 1'b1);
      end
      for (int k = 0; k < 8; k++) begin
         mv = memif_type'(MEMIF_W'($urandom));
         mv.active = 1'b1;
         mv.read = k[0];
         mv.multiplexed = k[1];
         memif = mv;
         settle();
      end
      memif.active = 1'b0;
      settle();
      stop_test();
   end

   initial begin
      #3_000_000;
      error_cnt++;
      stop_test();
   end
endmodule
